// [src/tio_status_store.sv]
`timescale 1ns/1ps
// Ending sequencer for a test I/O instruction: device-available and status-store paths.
// Assumes processor and storage bus controller pins are asynchronous; sampled twice.
// What this block does
// - Device-available path drives condition code zero
// - Accept on zero status, seq five, test latch
// - Request drop clears setup, test, seq five
// - Status word stored at location 64
// - Four conditions enter status-store path
// - Interrupt clears polling, stops clock unless seq three or four, remembers
// - Remember-interrupt clears control-unit-busy latch
// - Pseudo accept from interrupt, test, no reset
// - Pseudo accept raises storage request, address, cycle
// - Response sets latched address, clears suppress-out
// - During response drive address, marks, parity, store
// - Data request puts status out, drops request
// - Status bytes in place, zeros elsewhere
// - Accept sets latch, clears interrupt and request
// - Advance clears accept; late pulse ends cycle
// - After remember clears, code one then release
// - Request drop clears latches; late pulse clears address
// - Nonzero status after disconnect takes store path
module tio_status_store
  import tio_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic TEST_IO,
  input wire logic SELECT_CHANNEL,
  input wire logic OPERATIONAL_IN,
  input wire logic STATUS_IN,
  input wire logic SETUP_SET,
  input wire logic STATUS_DONE,
  input wire logic [STAT_W-1:0] STATUS_BITS,
  input wire logic CHAN_CTRL_CHECK,
  input wire logic CU_BUSY,
  input wire logic IFC_CHECK,
  input wire logic IFC_RESET,
  input wire logic SEQ_3_OR_4,
  input wire logic POLL_INT_SET,
  input wire logic STORAGE_RESPONSE,
  input wire logic STORAGE_DATA_REQ,
  input wire logic STORAGE_ACCEPT,
  input wire logic STORAGE_ADVANCE,
  output logic [1:0] CONDITION_CODE,
  output logic RELEASE,
  output logic STORAGE_REQUEST,
  output logic [ADDR_W-1:0] STORAGE_ADDRESS_LINES,
  output logic [MARK_W-1:0] STORAGE_MARKS,
  output logic STORAGE_PROTECT_PARITY,
  output logic STORE_CMD,
  output logic [DATA_W-1:0] STORAGE_DATA_IN_LINES,
  output logic CLOCK_RUN,
  output logic POLLING,
  output logic SUPPRESS_OUT,
  output logic CU_BUSY_LATCH
);
  localparam int NIN = 16;

  typedef enum {
    S_IDLE,
    S_ACCEPT,
    S_DESKEW,
    S_DONE
  } end_t;

  typedef struct packed {
    end_t phase;
    logic setup;
    logic test_io;
    logic seq5;
    logic intr;
    logic poll_int;
    logic remember;
    logic cu_busy;
    logic pseudo;
    logic isr;
    logic fixed_addr;
    logic fixed_latched;
    logic stor_cycle;
    logic acc;
    logic suppress;
    logic clk_run;
    logic polling;
    logic adv_q;
    logic [DLY_W-1:0] dly;
    logic [STAT_W-1:0] stat;
    logic [1:0] cc;
    logic rel;
    logic req;
    logic [ADDR_W-1:0] addr;
    logic [MARK_W-1:0] marks;
    logic parity;
    logic store;
    logic [DATA_W-1:0] data;
  } state_t;

  state_t st_ff, nxt_st;
  logic [NIN-1:0] raw_in, syn_in;
  logic [STAT_W-1:0] stat_syn;
  logic t_io, sel_ch, op_in, st_in, setup_set, st_done, cck, cub, icc;
  logic ifr, seq34, poll_set, resp, dreq, s_acc, s_adv;
  logic late_adv, cyc_done, adv_rise;

  // Gather pin levels for the synchroniser
  assign raw_in = {TEST_IO, SELECT_CHANNEL, OPERATIONAL_IN, STATUS_IN, SETUP_SET,
                   STATUS_DONE, CHAN_CTRL_CHECK, CU_BUSY, IFC_CHECK, IFC_RESET,
                   SEQ_3_OR_4, POLL_INT_SET, STORAGE_RESPONSE, STORAGE_DATA_REQ,
                   STORAGE_ACCEPT, STORAGE_ADVANCE};

  tio_sync #(.W(NIN)) u_sync_ctl (
    .clk(REF_CLK),
    .rst(RST),
    .d(raw_in),
    .q(syn_in)
  );

  tio_sync #(.W(STAT_W)) u_sync_stat (
    .clk(REF_CLK),
    .rst(RST),
    .d(STATUS_BITS),
    .q(stat_syn)
  );

  assign {t_io, sel_ch, op_in, st_in, setup_set, st_done, cck, cub, icc, ifr, seq34,
          poll_set, resp, dreq, s_acc, s_adv} = syn_in;

  // Edge of the advance pulse, and its delayed copies
  assign adv_rise = s_adv & ~st_ff.adv_q;

  tio_delay #(.CYC(LATE_ADV_CYC)) u_late_adv (
    .clk(REF_CLK),
    .rst(RST),
    .pulse_in(adv_rise),
    .pulse_out(late_adv)
  );

  tio_delay #(.CYC(CYC_DONE_CYC)) u_cyc_done (
    .clk(REF_CLK),
    .rst(RST),
    .pulse_in(adv_rise),
    .pulse_out(cyc_done)
  );

  // Status word image: status bits in their own byte lanes, zeros elsewhere
  function automatic logic [DATA_W-1:0] status_word(input logic [STAT_W-1:0] s);
    logic [DATA_W-1:0] w;
    w = '0;
    w[STAT_LSB +: STAT_W] = s;
    return w;
  endfunction

  // Sequencer next state
  always_comb begin
    nxt_st = st_ff;
    // Latch the test request and setup while the instruction is up
    if (t_io) begin
      nxt_st.test_io = 1'b1;
    end
    if (setup_set && t_io) begin
      nxt_st.setup = 1'b1;
    end
    if (poll_set) begin
      nxt_st.poll_int = 1'b1;
    end
    if (cub) begin
      nxt_st.cu_busy = 1'b1;
    end
    if (icc) begin
      nxt_st.suppress = 1'b1;
    end
    // A new instruction starts from clean status bytes, never stale ones
    if (t_io && !st_ff.test_io) begin
      nxt_st.stat = '0;
    end
    // Capture status once the control unit disconnects
    if (st_done && !op_in && !st_in) begin
      nxt_st.seq5 = st_ff.test_io;
      nxt_st.stat = stat_syn;
    end
    // Entry into the status-store path
    if (st_ff.test_io && !st_ff.intr && !st_ff.remember &&
        (cck || cub || icc ||
         (st_done && !op_in && !st_in && stat_syn != '0))) begin
      nxt_st.intr = 1'b1;
    end
    // Interrupt side effects
    if (st_ff.intr) begin
      nxt_st.poll_int = 1'b0;
      nxt_st.seq5 = 1'b0;
      nxt_st.remember = 1'b1;
      if (!seq34) begin
        nxt_st.clk_run = 1'b0;
      end
      if (st_ff.test_io && !ifr) begin
        nxt_st.pseudo = 1'b1;
      end
    end
    if (st_ff.remember) begin
      nxt_st.cu_busy = 1'b0;
    end
    // Pseudo accept raises the storage request
    // Only while the interrupt is pending, so one store per instruction
    if (st_ff.pseudo && st_ff.intr && !st_ff.acc && !st_ff.fixed_latched) begin
      nxt_st.isr = 1'b1;
    end
    if (st_ff.isr) begin
      nxt_st.fixed_addr = 1'b1;
      nxt_st.stor_cycle = 1'b1;
    end
    // Request rises once per store and stays down after the data request
    if (dreq) begin
      nxt_st.req = 1'b0;
    end else if (st_ff.isr && !st_ff.fixed_latched) begin
      nxt_st.req = 1'b1;
    end
    // Storage response drives address, marks, parity and store
    if (resp && st_ff.fixed_addr) begin
      nxt_st.fixed_latched = 1'b1;
      nxt_st.suppress = 1'b0;
    end
    nxt_st.addr = (resp && st_ff.fixed_addr) ? STATUS_WORD_ADDR : '0;
    nxt_st.marks = (resp && st_ff.fixed_latched) ? ALL_MARKS : '0;
    nxt_st.parity = resp && st_ff.remember;
    nxt_st.store = resp && st_ff.remember;
    // Data request puts the status word on the data lines
    if (dreq && st_ff.fixed_latched && st_ff.remember) begin
      nxt_st.data = status_word(st_ff.stat);
    end else begin
      nxt_st.data = '0;
    end
    // Accept from the controller
    if (s_acc && st_ff.isr) begin
      nxt_st.acc = 1'b1;
      if (st_ff.fixed_addr) begin
        nxt_st.intr = 1'b0;
      end
    end
    if (st_ff.acc) begin
      nxt_st.isr = 1'b0;
    end
    nxt_st.adv_q = s_adv;
    if (adv_rise) begin
      nxt_st.acc = 1'b0;
    end
    if (late_adv) begin
      nxt_st.stor_cycle = 1'b0;
    end
    if (!st_ff.stor_cycle && st_ff.remember && !st_ff.intr && st_ff.fixed_addr) begin
      nxt_st.remember = 1'b0;
    end
    // Late completion clears the fixed address in two steps
    if (cyc_done) begin
      nxt_st.fixed_latched = 1'b0;
    end
    if (!st_ff.fixed_latched && !st_ff.stor_cycle && !st_ff.remember &&
        st_ff.fixed_addr && !st_ff.isr) begin
      nxt_st.fixed_addr = 1'b0;
    end
    // Ending handshake toward the processor
    case (st_ff.phase)
      S_IDLE: begin
        if (st_ff.test_io && st_ff.seq5 && st_ff.stat == '0 && !st_ff.intr &&
            !op_in && !st_in) begin
          nxt_st.cc = CC_ZERO;
          nxt_st.rel = 1'b1;
          nxt_st.phase = S_ACCEPT;
        end else if (st_ff.pseudo && st_ff.remember && !nxt_st.remember) begin
          nxt_st.cc = CC_ONE;
          nxt_st.dly = DLY_W'(DESKEW_CYC - 1);
          nxt_st.phase = S_DESKEW;
        end
      end
      S_DESKEW: begin
        if (st_ff.dly == '0) begin
          nxt_st.rel = 1'b1;
          nxt_st.phase = S_DONE;
        end else begin
          nxt_st.dly = st_ff.dly - 1'b1;
        end
      end
      S_ACCEPT, S_DONE: begin
        // Code holds until the request drops
        if (!t_io) begin
          nxt_st.rel = 1'b0;
          nxt_st.cc = CC_ZERO;
          nxt_st.phase = S_IDLE;
        end
      end
      default: begin
        nxt_st.phase = S_IDLE;
      end
    endcase
    // Dropping the test request ends the instruction
    if (!t_io && st_ff.test_io && (st_ff.phase == S_ACCEPT || st_ff.phase == S_DONE)) begin
      nxt_st.setup = 1'b0;
      nxt_st.test_io = 1'b0;
      nxt_st.pseudo = 1'b0;
    end
    if (!st_ff.test_io && st_ff.seq5) begin
      nxt_st.seq5 = 1'b0;
    end
    // Clock restarts once the storage cycle is fully over
    if (!st_ff.remember && !st_ff.intr && !st_ff.fixed_addr) begin
      nxt_st.clk_run = 1'b1;
    end
    // Idle indication, registered so the pin comes from a flop
    nxt_st.polling = !nxt_st.test_io && !nxt_st.remember && !nxt_st.fixed_addr;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_ff <= '0;
      st_ff.phase <= S_IDLE;
      st_ff.clk_run <= 1'b1;
      st_ff.polling <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign CONDITION_CODE = st_ff.cc;
  assign RELEASE = st_ff.rel;
  assign STORAGE_REQUEST = st_ff.req;
  assign STORAGE_ADDRESS_LINES = st_ff.addr;
  assign STORAGE_MARKS = st_ff.marks;
  assign STORAGE_PROTECT_PARITY = st_ff.parity;
  assign STORE_CMD = st_ff.store;
  assign STORAGE_DATA_IN_LINES = st_ff.data;
  assign CLOCK_RUN = st_ff.clk_run;
  assign POLLING = st_ff.polling;
  assign SUPPRESS_OUT = st_ff.suppress;
  assign CU_BUSY_LATCH = st_ff.cu_busy;
endmodule

// [common/tio_pkg.sv]
// Constants, types and timing figures shared by the test I/O ending sequencer.
// Assumes a single 100 MHz reference clock.
package tio_pkg;
  // Clock and delay figures
  localparam int CLK_MHZ = 100;
  localparam int DESKEW_NS = 50;
  localparam int LATE_ADV_NS = 30;
  localparam int CYC_DONE_NS = 60;
  localparam int DESKEW_CYC = (DESKEW_NS * CLK_MHZ + 999) / 1000;
  localparam int LATE_ADV_CYC = (LATE_ADV_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_DONE_CYC = (CYC_DONE_NS * CLK_MHZ + 999) / 1000;
  localparam int DLY_W = 4;
  // Storage bus figures
  localparam int ADDR_W = 24;
  localparam int DATA_W = 64;
  localparam int MARK_W = 8;
  localparam int STAT_W = 16;
  localparam int STAT_LSB = 0;
  localparam logic [ADDR_W-1:0] STATUS_WORD_ADDR = 24'h000040;
  localparam logic [MARK_W-1:0] ALL_MARKS = 8'hff;
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_ONE = 2'h1;
endpackage

// [src/tio_delay.sv]
`timescale 1ns/1ps
// Delays a one-cycle pulse by a fixed number of cycles.
// Assumes the pulse comes from logic on the same clock.
module tio_delay
  import tio_pkg::*;
#(
  parameter int CYC = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pulse_in,
  output logic pulse_out
);
  typedef struct packed {
    logic [DLY_W-1:0] cnt;
    logic busy;
    logic out;
  } dly_t;
  dly_t st_ff, nxt_st;

  // Count down from the start pulse, emit once at the end
  always_comb begin
    nxt_st = st_ff;
    nxt_st.out = 1'b0;
    if (pulse_in) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = DLY_W'(CYC - 1);
    end else if (st_ff.busy) begin
      if (st_ff.cnt == '0) begin
        nxt_st.busy = 1'b0;
        nxt_st.out = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse_out = st_ff.out;
endmodule

// [src/tio_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of level inputs from the pins.
// Assumes inputs are asynchronous to the clock.
module tio_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t st_ff, nxt_st;

  // First stage feeds only the second
  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule

// [tb/tio_checker.sv]
`timescale 1ns/1ps
// Pin-level checks on the test I/O ending sequencer.
// Assumes one clock domain and a storage controller that holds each step several cycles.
module tio_checker
  import tio_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic TEST_IO,
  input wire logic STATUS_DONE,
  input wire logic [STAT_W-1:0] STATUS_BITS,
  input wire logic IFC_RESET,
  input wire logic SEQ_3_OR_4,
  input wire logic STORAGE_RESPONSE,
  input wire logic STORAGE_DATA_REQ,
  input wire logic [1:0] CONDITION_CODE,
  input wire logic RELEASE,
  input wire logic STORAGE_REQUEST,
  input wire logic [ADDR_W-1:0] STORAGE_ADDRESS_LINES,
  input wire logic [MARK_W-1:0] STORAGE_MARKS,
  input wire logic STORAGE_PROTECT_PARITY,
  input wire logic STORE_CMD,
  input wire logic [DATA_W-1:0] STORAGE_DATA_IN_LINES,
  input wire logic CLOCK_RUN,
  input wire logic POLLING,
  input wire logic SUPPRESS_OUT
);
  // Deskew window around the nominal release delay
  localparam int DLO = DESKEW_CYC - 1;
  localparam int DHI = DESKEW_CYC + 1;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Store command, parity and marks of one storage cycle
  sequence store_gate_s;
    STORE_CMD && STORAGE_PROTECT_PARITY && STORAGE_MARKS == ALL_MARKS;
  endsequence
  // Request withdrawn, nothing above the status lanes
  sequence data_gate_s;
    !STORAGE_REQUEST && STORAGE_DATA_IN_LINES[DATA_W-1:STAT_W] == '0;
  endsequence
  addr_fixed_a: assert property (STORAGE_ADDRESS_LINES != '0 |-> STORAGE_ADDRESS_LINES == STATUS_WORD_ADDR)
    else $error("address lines not the status word location");
  store_gate_a: assert property ($rose(STORAGE_RESPONSE) |-> ##[1:6] store_gate_s)
    else $error("store command or marks missing during response");
  data_gate_a: assert property ($rose(STORAGE_DATA_REQ) |-> ##[1:4] data_gate_s)
    else $error("data request did not withdraw the request");
  data_idle_a: assert property (!STORAGE_DATA_REQ [*4] |-> STORAGE_DATA_IN_LINES == '0)
    else $error("data lines driven without data request");
  req_drop_a: assert property ($fell(STORAGE_REQUEST) |-> $past(STORAGE_DATA_REQ))
    else $error("request dropped without data request");
  deskew_a: assert property ($rose(CONDITION_CODE == CC_ONE) |-> !RELEASE ##[DLO:DHI] $rose(RELEASE))
    else $error("release not one deskew after code one");
  cc_hold_a: assert property (RELEASE && TEST_IO |=> $stable(CONDITION_CODE))
    else $error("condition code moved while release up");
  cc_status_a: assert property ($rose(RELEASE) && STATUS_DONE |-> CONDITION_CODE == (STATUS_BITS == '0 ? CC_ZERO : CC_ONE))
    else $error("condition code does not match ending status");
  end_op_a: assert property ($fell(TEST_IO) && RELEASE |-> ##[1:5] (!RELEASE && CONDITION_CODE == CC_ZERO) ##[0:12] POLLING)
    else $error("request drop did not end the operation");
  clock_stop_a: assert property ($rose(STORAGE_REQUEST) |-> CLOCK_RUN == SEQ_3_OR_4)
    else $error("clock run wrong on entry to store path");
  suppress_a: assert property ($rose(STORAGE_RESPONSE) && SUPPRESS_OUT |-> ##[1:4] !SUPPRESS_OUT)
    else $error("suppress out not cleared by response");
  pseudo_block_a: assert property (IFC_RESET [*4] |-> !$rose(STORAGE_REQUEST))
    else $error("storage request during interface reset");
endmodule
bind tio_status_store tio_checker i_tio_checker (.*);

// [tb/tio_storage_model.sv]
`timescale 1ns/1ps
// Storage bus controller model: answers each storage request step by step.
// Assumes design outputs change on the rising clock edge.
module tio_storage_model
  import tio_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] gap,
  input wire logic req,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [MARK_W-1:0] marks,
  input wire logic [DATA_W-1:0] data,
  output logic resp,
  output logic dreq,
  output logic acc,
  output logic adv,
  output logic [ADDR_W-1:0] addr_seen,
  output logic [MARK_W-1:0] mark_seen,
  output logic [DATA_W-1:0] data_seen
);
  // Holds one handshake step for gap cycles, so prompt and slow answers both occur
  task automatic hold();
    repeat (gap) @(posedge clk);
  endtask
  // Response, data request, accept, then advance once the word is kept
  initial begin
    {resp, dreq, acc, adv} = 4'h0;
    {addr_seen, mark_seen, data_seen} = '0;
    forever begin
      @(posedge clk);
      if (req === 1'b1) begin
        hold();
        resp <= 1'b1;
        hold();
        addr_seen <= addr;
        mark_seen <= marks;
        {resp, dreq} <= 2'h1;
        hold();
        data_seen <= data;
        {dreq, acc} <= 2'h1;
        hold();
        {acc, adv} <= 2'h1;
        hold();
        adv <= 1'b0;
        hold();
      end
    end
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
// Self-checking bench: device-available path, then each store-path cause.
// Assumes the storage model answers every storage request.
module testbench;
  import tio_pkg::*;
  logic REF_CLK, RST, TEST_IO, SELECT_CHANNEL, OPERATIONAL_IN, STATUS_IN, SETUP_SET;
  logic STATUS_DONE, CHAN_CTRL_CHECK, CU_BUSY, IFC_CHECK, IFC_RESET, SEQ_3_OR_4;
  logic POLL_INT_SET, STORAGE_RESPONSE, STORAGE_DATA_REQ, STORAGE_ACCEPT, STORAGE_ADVANCE;
  logic RELEASE, STORAGE_REQUEST, STORAGE_PROTECT_PARITY, STORE_CMD, CLOCK_RUN, POLLING;
  logic SUPPRESS_OUT, CU_BUSY_LATCH;
  logic [1:0] CONDITION_CODE;
  logic [STAT_W-1:0] STATUS_BITS;
  logic [ADDR_W-1:0] STORAGE_ADDRESS_LINES, addr_seen;
  logic [MARK_W-1:0] STORAGE_MARKS, mark_seen;
  logic [DATA_W-1:0] STORAGE_DATA_IN_LINES, data_seen;
  logic [3:0] gap;
  int error_cnt, checks;
  tio_status_store i_tio_status_store (.*);
  tio_storage_model i_tio_storage_model (.clk(REF_CLK), .gap(gap), .req(STORAGE_REQUEST),
    .addr(STORAGE_ADDRESS_LINES), .marks(STORAGE_MARKS), .data(STORAGE_DATA_IN_LINES),
    .resp(STORAGE_RESPONSE), .dreq(STORAGE_DATA_REQ), .acc(STORAGE_ACCEPT),
    .adv(STORAGE_ADVANCE), .addr_seen(addr_seen), .mark_seen(mark_seen),
    .data_seen(data_seen));
  // 100 MHz reference clock
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // Compare and count
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a level, sampled on the falling edge
  task automatic wait_sig(ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl && n < 300) begin
      @(negedge REF_CLK);
      n++;
    end
    chk(DATA_W'(sig), DATA_W'(lvl));
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog: six operations need a few hundred cycles, this allows 20000
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  // Case 0 zero status, 1 nonzero status, 2 control check, 3 busy with clock kept,
  // 4 interface check, 5 control check held off by interface reset
  initial begin
    {TEST_IO, SELECT_CHANNEL, OPERATIONAL_IN, STATUS_IN, SETUP_SET, STATUS_DONE} = '0;
    {CHAN_CTRL_CHECK, CU_BUSY, IFC_CHECK, IFC_RESET, SEQ_3_OR_4, POLL_INT_SET} = '0;
    STATUS_BITS = '0;
    gap = 4'h5;
    error_cnt = 0;
    checks = 0;
    RST = 1'b1;
    repeat (6) @(posedge REF_CLK);
    RST <= 1'b0;
    @(negedge REF_CLK);
    chk(DATA_W'({RELEASE, STORAGE_REQUEST, CLOCK_RUN, POLLING, CONDITION_CODE}), 64'hc);
    for (int k = 0; k < 6; k++) begin
      @(posedge REF_CLK);
      gap <= k[0] ? 4'h9 : 4'h5;
      STATUS_BITS <= (k == 1) ? 16'h0c05 : 16'h0000;
      {TEST_IO, SELECT_CHANNEL, SETUP_SET, POLL_INT_SET} <= 4'hf;
      repeat (4) @(posedge REF_CLK);
      STATUS_DONE <= (k < 2);
      {IFC_RESET, CHAN_CTRL_CHECK, IFC_CHECK} <= {k == 5, k == 2 || k == 5, k == 4};
      {CU_BUSY, SEQ_3_OR_4} <= {k == 3, k == 3};
      if (k == 5) begin
        repeat (20) @(negedge REF_CLK);
        chk(DATA_W'(STORAGE_REQUEST), 64'h0);
        @(posedge REF_CLK);
        IFC_RESET <= 1'b0;
      end
      if (k > 0) begin
        wait_sig(STORAGE_REQUEST, 1'b1);
        chk(DATA_W'(CLOCK_RUN), DATA_W'(k == 3));
        @(posedge REF_CLK);
        {CHAN_CTRL_CHECK, IFC_CHECK, CU_BUSY, STATUS_DONE} <= 4'h0;
      end
      wait_sig(RELEASE, 1'b1);
      chk(DATA_W'(CONDITION_CODE), (k == 0) ? 64'(CC_ZERO) : 64'(CC_ONE));
      if (k > 0) begin
        chk(DATA_W'(addr_seen), DATA_W'(STATUS_WORD_ADDR));
        chk(DATA_W'(mark_seen), DATA_W'(ALL_MARKS));
        chk(data_seen, (k == 1) ? 64'h0c05 : 64'h0);
        chk(DATA_W'({CU_BUSY_LATCH, SUPPRESS_OUT, STORAGE_REQUEST}), 64'h0);
      end
      @(posedge REF_CLK);
      {TEST_IO, SELECT_CHANNEL, SETUP_SET, POLL_INT_SET} <= 4'h0;
      wait_sig(RELEASE, 1'b0);
      repeat (12) @(negedge REF_CLK);
      chk(DATA_W'({POLLING, CONDITION_CODE}), 64'h4);
      $display("test %0d done", k);
    end
    report_and_stop();
  end
endmodule
